// [core/cswd_pkg.sv]
package cswd_pkg;

  // Register map over the plain register port
  localparam int          REG_ADDR_W        = 4;
  localparam logic [3:0]  ADDR_BUS_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_DECODE_STAT  = 4'h1;
  localparam logic [3:0]  ADDR_ACCESS_LO    = 4'h2;
  localparam logic [3:0]  ADDR_ACCESS_HI    = 4'h3;

  // Control register layout
  localparam logic [15:0] CTRL_RESET        = 16'h200f;
  localparam logic [15:0] CTRL_WRITE_MASK   = 16'h21ff;
  localparam int          BIT_TIMER_EN      = 13;
  localparam int          BIT_MUX_EN        = 8;
  localparam int          BIT_LONG_LSB      = 4;
  localparam int          BIT_WORD_LSB      = 0;

  // Address map
  localparam logic [7:0]  TOP_EXTERNAL      = 8'h00;
  localparam logic [7:0]  TOP_DRAM          = 8'h01;
  localparam logic [31:0] ROM_WIN_END       = 32'h0003_ffff;
  localparam logic [31:0] CS0_ROM_START     = 32'h0020_0000;
  localparam logic [31:0] PERI_START        = 32'hffff_8000;
  localparam logic [31:0] PERI_END          = 32'hffff_87ff;
  localparam logic [31:0] RAM_START         = 32'hffff_f000;
  localparam int          MUX_WIDTH_BIT     = 14;
  localparam logic [31:0] ROM_SIZE_256K     = 32'h0004_0000;

  // Bus width codes
  typedef enum logic [1:0]
  {
    CSWD_W8  = 2'h0,
    CSWD_W16 = 2'h1,
    CSWD_W32 = 2'h2
  } cswd_width_e;

  // Decoded space codes
  typedef enum logic [3:0]
  {
    CSWD_SP_NONE = 4'h0,
    CSWD_SP_ROM  = 4'h1,
    CSWD_SP_CS0  = 4'h2,
    CSWD_SP_CS1  = 4'h3,
    CSWD_SP_CS2  = 4'h4,
    CSWD_SP_CS3  = 4'h5,
    CSWD_SP_DRAM = 4'h6,
    CSWD_SP_PERI = 4'h7,
    CSWD_SP_RAM  = 4'h8
  } cswd_space_e;

  // Resolve one ordinary space width from its long and word bits
  function automatic cswd_width_e cswd_width(input logic long_size,
                                             input logic word_size);
    if (long_size)
    begin
      return CSWD_W32;
    end
    return word_size ? CSWD_W16 : CSWD_W8;
  endfunction

endpackage

// [core/cswd_addr_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module cswd_addr_decode
  import cswd_pkg::*;
(
  // Mode
  input  wire logic [31:0]        i_rom_size,
  input  wire logic               i_rom_en,
  input  wire logic               i_single_chip,
  // Address
  input  wire logic [31:0]        i_addr,
  // Result
  output cswd_pkg::cswd_space_e   o_space,
  output logic      [3:0]         o_cs_n,
  output logic      [21:0]        o_ext_addr
);
  logic top_ext;
  logic top_dram;
  logic in_rom;
  logic in_rom_win;
  logic cs_ok;
  logic [1:0] cs_idx;

  assign top_ext    = (i_addr[31:24] == TOP_EXTERNAL);
  assign top_dram   = (i_addr[31:24] == TOP_DRAM);
  assign in_rom_win = top_ext && (i_addr <= ROM_WIN_END);
  assign in_rom     = i_rom_en && in_rom_win && (i_addr < i_rom_size);
  assign cs_idx     = i_addr[23:22];
  // ROM mode: low 2 Mbytes of first space belong to ROM window or reserved
  assign cs_ok      = top_ext && !i_single_chip &&
                      (!i_rom_en || cs_idx != 2'h0 ||
                       i_addr >= CS0_ROM_START);
  assign o_ext_addr = i_addr[21:0];

  always_comb
  begin
    o_cs_n = 4'hf;
    if (cs_ok)
    begin
      o_cs_n[cs_idx] = 1'b0;
    end
  end

  always_comb
  begin
    if (in_rom)
    begin
      o_space = CSWD_SP_ROM;
    end
    else if (cs_ok)
    begin
      o_space = cswd_space_e'({2'b00, cs_idx} + CSWD_SP_CS0);
    end
    else if (top_dram && !i_single_chip)
    begin
      o_space = CSWD_SP_DRAM;
    end
    else if (i_addr >= PERI_START && i_addr <= PERI_END)
    begin
      o_space = CSWD_SP_PERI;
    end
    else if (i_addr >= RAM_START)
    begin
      o_space = CSWD_SP_RAM;
    end
    else
    begin
      o_space = CSWD_SP_NONE;
    end
  end
endmodule
`default_nettype wire

// [core/cswd_width_resolve.sv]
`timescale 1ns/1ps
`default_nettype none
module cswd_width_resolve
  import cswd_pkg::*;
(
  // Configuration
  input  wire logic [15:0]        i_ctrl,
  input  wire logic               i_rom_en,
  input  wire logic               i_mode_wide,
  input  wire logic               i_mux_addr_bit,
  // Resolved widths
  output cswd_pkg::cswd_width_e   o_width0,
  output cswd_pkg::cswd_width_e   o_width1,
  output cswd_pkg::cswd_width_e   o_width2,
  output cswd_pkg::cswd_width_e   o_width3
);
  logic        mux_io_enable;
  cswd_width_e pin_width0;
  cswd_width_e mux_width3;

  assign mux_io_enable = i_ctrl[BIT_MUX_EN];
  // Mode pin picks between the two package choices: 32 bits when set, else 16
  assign pin_width0 = i_mode_wide ? CSWD_W32 : CSWD_W16;
  assign mux_width3 = i_mux_addr_bit ? CSWD_W16 : CSWD_W8;

  assign o_width0 = i_rom_en
                  ? cswd_width(i_ctrl[BIT_LONG_LSB],
                               i_ctrl[BIT_WORD_LSB])
                  : pin_width0;
  assign o_width1 = cswd_width(i_ctrl[BIT_LONG_LSB + 1],
                               i_ctrl[BIT_WORD_LSB + 1]);
  assign o_width2 = cswd_width(i_ctrl[BIT_LONG_LSB + 2],
                               i_ctrl[BIT_WORD_LSB + 2]);
  assign o_width3 = mux_io_enable ? mux_width3
                  : cswd_width(i_ctrl[BIT_LONG_LSB + 3],
                               i_ctrl[BIT_WORD_LSB + 3]);
endmodule
`default_nettype wire

// [core/cswd_space_config.sv]
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cswd_space_config
  import cswd_pkg::*;
#(
  parameter logic [31:0] ROM_SIZE = ROM_SIZE_256K
)
(
  // Clock and power-on reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_arst_n,
  // Register port
  input  wire logic [cswd_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [15:0]                   i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [15:0]                   o_reg_rdata,
  // Mode pins
  input  wire logic                          i_rom_en_pin,
  input  wire logic                          i_single_chip_pin,
  input  wire logic                          i_mode_wide_pin,
  // Access being decoded, same clock domain
  input  wire logic [31:0]                   i_acc_addr,
  input  wire logic                          i_acc_valid,
  input  wire logic                          i_acc_timer_reg,
  // Decode result
  output cswd_pkg::cswd_space_e              o_space,
  output logic      [3:0]                    o_chip_select_n,
  output logic      [21:0]                   o_ext_addr,
  output logic                               o_acc_reserved,
  output logic                               o_timer_access_ok,
  // Sequencer configuration
  output cswd_pkg::cswd_width_e              o_width0,
  output cswd_pkg::cswd_width_e              o_width1,
  output cswd_pkg::cswd_width_e              o_width2,
  output cswd_pkg::cswd_width_e              o_width3,
  output cswd_pkg::cswd_width_e              o_acc_width,
  output logic                               o_mux_io_enable
);
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [1:0]  rom_meta;
  logic [1:0]  single_meta;
  logic [1:0]  wide_meta;
  logic        rom_en;
  logic        single_chip;
  logic        mode_wide;
  logic [15:0] bus_width_and_mux_control;
  logic [15:0] next_ctrl;
  logic        timer_reg_access_enable;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_lo;
  logic        sel_hi;
  logic [15:0] read_mux;
  logic [15:0] stat_word;
  logic [31:0] last_reserved_addr;
  logic [7:0]  reserved_count;
  logic [7:0]  next_reserved_count;
  logic        reserved_hit;
  cswd_space_e space;
  cswd_width_e acc_width;

  // Reset release through two flops
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Mode pins are asynchronous straps
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rom_meta    <= 2'h0;
      single_meta <= 2'h0;
      wide_meta   <= 2'h0;
    end
    else
    begin
      rom_meta    <= {rom_meta[0], i_rom_en_pin};
      single_meta <= {single_meta[0], i_single_chip_pin};
      wide_meta   <= {wide_meta[0], i_mode_wide_pin};
    end
  end
  assign rom_en      = rom_meta[1];
  assign single_chip = single_meta[1];
  assign mode_wide   = wide_meta[1];

  // Register decode
  assign sel_ctrl = (i_reg_addr == ADDR_BUS_CTRL);
  assign sel_stat = (i_reg_addr == ADDR_DECODE_STAT);
  assign sel_lo   = (i_reg_addr == ADDR_ACCESS_LO);
  assign sel_hi   = (i_reg_addr == ADDR_ACCESS_HI);

  // Reserved bits never stored, so they read back zero
  assign next_ctrl = (i_reg_wr && sel_ctrl)
                   ? (i_reg_wdata & CTRL_WRITE_MASK)
                   : bus_width_and_mux_control;

  // Only power-on reset loads CTRL_RESET; no other reset source reaches it
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_width_and_mux_control <= CTRL_RESET;
    end
    else
    begin
      bus_width_and_mux_control <= next_ctrl;
    end
  end

  assign timer_reg_access_enable = bus_width_and_mux_control[BIT_TIMER_EN];
  assign o_mux_io_enable = bus_width_and_mux_control[BIT_MUX_EN];
  assign o_timer_access_ok = i_acc_valid && i_acc_timer_reg &&
                             timer_reg_access_enable;

  cswd_addr_decode u_decode
  (
    .i_rom_size    (ROM_SIZE),
    .i_rom_en      (rom_en),
    .i_single_chip (single_chip),
    .i_addr        (i_acc_addr),
    .o_space       (space),
    .o_cs_n        (o_chip_select_n),
    .o_ext_addr    (o_ext_addr)
  );

  cswd_width_resolve u_width
  (
    .i_ctrl         (bus_width_and_mux_control),
    .i_rom_en       (rom_en),
    .i_mode_wide    (mode_wide),
    .i_mux_addr_bit (i_acc_addr[MUX_WIDTH_BIT]),
    .o_width0       (o_width0),
    .o_width1       (o_width1),
    .o_width2       (o_width2),
    .o_width3       (o_width3)
  );

  assign o_space        = space;
  assign reserved_hit   = i_acc_valid && (space == CSWD_SP_NONE);
  assign o_acc_reserved = reserved_hit;

  // Width of the access in flight, for the sequencer
  always_comb
  begin
    case (space)
      CSWD_SP_CS0:  acc_width = o_width0;
      CSWD_SP_CS1:  acc_width = o_width1;
      CSWD_SP_CS2:  acc_width = o_width2;
      CSWD_SP_CS3:  acc_width = o_width3;
      CSWD_SP_PERI: acc_width = CSWD_W16;
      CSWD_SP_NONE: acc_width = CSWD_W8;
      default:      acc_width = CSWD_W32;
    endcase
  end
  assign o_acc_width = acc_width;

  // Capture of the last reserved access, for debug of software faults
  assign next_reserved_count = (reserved_count == 8'hff)
                             ? reserved_count
                             : reserved_count + 8'h01;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_reserved_addr <= 32'h0000_0000;
      reserved_count     <= 8'h00;
    end
    else if (reserved_hit)
    begin
      last_reserved_addr <= i_acc_addr;
      reserved_count     <= next_reserved_count;
    end
  end

  assign stat_word = {reserved_count,
                      1'b0, mode_wide, single_chip, rom_en,
                      space};

  assign read_mux = sel_ctrl ? bus_width_and_mux_control
                  : sel_stat ? stat_word
                  : sel_lo   ? last_reserved_addr[15:0]
                  : sel_hi   ? last_reserved_addr[31:16]
                  : 16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_reg_rdata <= 16'h0000;
    end
    else
    begin
      o_reg_rdata <= i_reg_rd ? read_mux : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [testbench/cswd_space_config_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cswd_space_config_props
  import cswd_pkg::*;
(
  // Clock, reset and register port
  input wire logic                              i_mclk,
  input wire logic                              i_arst_n,
  input wire logic [cswd_pkg::REG_ADDR_W-1:0]   i_reg_addr,
  input wire logic [15:0]                       i_reg_wdata,
  input wire logic                              i_reg_wr,
  input wire logic                              i_reg_rd,
  input wire logic [15:0]                       o_reg_rdata,
  // Access decode
  input wire logic [31:0]                       i_acc_addr,
  input wire logic                              i_acc_valid,
  input wire logic [3:0]                        o_chip_select_n,
  input wire logic                              o_acc_reserved,
  input wire logic                              o_timer_access_ok,
  input var  cswd_pkg::cswd_space_e             o_space,
  input var  cswd_pkg::cswd_width_e             o_width1,
  input var  cswd_pkg::cswd_width_e             o_width2,
  input var  cswd_pkg::cswd_width_e             o_acc_width,
  input wire logic                              o_mux_io_enable
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_ctrl_wr;
    i_reg_wr && i_reg_addr == ADDR_BUS_CTRL;
  endsequence
  sequence s_ctrl_rd;
    i_reg_rd && i_reg_addr == ADDR_BUS_CTRL;
  endsequence

  property p_wr_rd;
    s_ctrl_wr ##1 !i_reg_wr ##1 s_ctrl_rd
      |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 16'h21ff);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
  property p_rd_resv;
    s_ctrl_rd |=> (o_reg_rdata & 16'hde00) == 16'h0000;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved set");
  property p_mux_bit;
    s_ctrl_wr |=> o_mux_io_enable == $past(i_reg_wdata[8]);
  endproperty
  a_mux_bit: assert property (p_mux_bit) else $error("mux bit");
  property p_long;
    s_ctrl_wr ##0 i_reg_wdata[5] |=> o_width1 == CSWD_W32;
  endproperty
  a_long: assert property (p_long) else $error("long width");
  property p_word;
    s_ctrl_wr ##0 !i_reg_wdata[6]
      |=> o_width2 == ($past(i_reg_wdata[2]) ? CSWD_W16 : CSWD_W8);
  endproperty
  a_word: assert property (p_word) else $error("word width");
  property p_mux_w;
    i_acc_valid && o_mux_io_enable && o_space == CSWD_SP_CS3
      |-> o_acc_width == (i_acc_addr[14] ? CSWD_W16 : CSWD_W8);
  endproperty
  a_mux_w: assert property (p_mux_w) else $error("mux width");
  property p_cs_sel;
    i_acc_valid && o_space inside {[CSWD_SP_CS0:CSWD_SP_CS3]}
      |-> o_chip_select_n == ~(4'b0001 << i_acc_addr[23:22]);
  endproperty
  a_cs_sel: assert property (p_cs_sel) else $error("select");
  property p_cs_top;
    i_acc_addr[31:24] != 8'h00 |-> o_chip_select_n == 4'hf;
  endproperty
  a_cs_top: assert property (p_cs_top) else $error("select off");
  property p_timer;
    s_ctrl_wr ##0 !i_reg_wdata[13] |=> !o_timer_access_ok;
  endproperty
  a_timer: assert property (p_timer) else $error("timer gate");
  property p_resv;
    i_acc_valid && i_acc_addr[31:25] != 7'h00 && i_acc_addr < PERI_START
      |-> o_acc_reserved;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved hit");
  property p_dram;
    i_acc_valid && i_acc_addr[31:24] == TOP_DRAM && !o_acc_reserved
      |-> o_space == CSWD_SP_DRAM;
  endproperty
  a_dram: assert property (p_dram) else $error("dram space");
endmodule

bind cswd_space_config cswd_space_config_props chk_u
(
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_acc_addr(i_acc_addr),
  .i_acc_valid(i_acc_valid), .o_chip_select_n(o_chip_select_n),
  .o_acc_reserved(o_acc_reserved), .o_timer_access_ok(o_timer_access_ok),
  .o_space(o_space), .o_width1(o_width1), .o_width2(o_width2),
  .o_acc_width(o_acc_width), .o_mux_io_enable(o_mux_io_enable)
);
`default_nettype wire

// [testbench/cswd_ext_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module cswd_ext_dev
(
  // Select lines from the block
  input  wire logic [3:0] i_chip_select_n,
  // Index of the answering device, 4 idle, 7 clash
  output logic      [2:0] o_dev
);
  always_comb
  begin
    case (i_chip_select_n)
      4'b1110: o_dev = 3'h0;
      4'b1101: o_dev = 3'h1;
      4'b1011: o_dev = 3'h2;
      4'b0111: o_dev = 3'h3;
      4'b1111: o_dev = 3'h4;
      default: o_dev = 3'h7;
    endcase
  end
endmodule
`default_nettype wire

// [testbench/cswd_space_config_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cswd_space_config_tb_top;
  import cswd_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [3:0]  ra = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        rom = 1'b1;
  logic        sgl = 1'b0;
  logic        wide = 1'b1;
  logic [31:0] aa = 32'h0000_0000;
  logic        av = 1'b0;
  logic        at = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  cs_n;
  logic [21:0] ext;
  logic        resv;
  logic        tok;
  logic        mux;
  logic [2:0]  dev;
  cswd_space_e sp;
  cswd_width_e w0, w1, w2, w3, aw;
  int          n_mismatch = 0;
  int          n_checks = 0;

  initial forever #50 i_mclk = ~i_mclk;

  cswd_space_config dut_u
  (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
    .i_rom_en_pin(rom), .i_single_chip_pin(sgl), .i_mode_wide_pin(wide),
    .i_acc_addr(aa), .i_acc_valid(av), .i_acc_timer_reg(at), .o_space(sp),
    .o_chip_select_n(cs_n), .o_ext_addr(ext), .o_acc_reserved(resv),
    .o_timer_access_ok(tok), .o_width0(w0), .o_width1(w1), .o_width2(w2),
    .o_width3(w3), .o_acc_width(aw), .o_mux_io_enable(mux)
  );
  cswd_ext_dev part_u (.i_chip_select_n(cs_n), .o_dev(dev));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge i_mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge i_mclk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Power-on reset with new straps; the control register reloads CTRL_RESET and may be written again after
  task automatic por(input logic r, input logic w, input logic s);
    @(posedge i_mclk);
    i_arst_n <= 1'b0;
    rom <= r;
    wide <= w;
    sgl <= s;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic wid(input cswd_width_e e0, e1, e2, e3);
    #1;
    chk(w0, e0);
    chk(w1, e1);
    chk(w2, e2);
    chk(w3, e3);
  endtask
  task automatic acc(input logic [31:0] a, input cswd_space_e es,
                     input logic [3:0] ec, input logic er, input logic t);
    @(posedge i_mclk);
    aa <= a;
    av <= 1'b1;
    at <= t;
    #1;
    chk(sp, es);
    chk(cs_n, ec);
    chk(resv, er);
    chk(ext, a[21:0]);
    chk(dev, ec == 4'hf ? 3'h4 : {1'b0, ec[0] ? (ec[1] ? (ec[2] ? 2'h3 :
        2'h2) : 2'h1) : 2'h0});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge i_mclk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd(ADDR_BUS_CTRL, 16'h200f);
    wid(CSWD_W16, CSWD_W16, CSWD_W16, CSWD_W16);
    chk(mux, 1'b0);
    // Timer registers sit in peripheral space, no chip select before setup
    acc(32'hffff_8000, CSWD_SP_PERI, 4'hf, 1'b0, 1'b1);
    chk(tok, 1'b1);
    // First setup write of this power-on, before any chip-select traffic
    wr(ADDR_BUS_CTRL, 16'h0024);
    wid(CSWD_W8, CSWD_W32, CSWD_W16, CSWD_W8);
    acc(32'h0000_0000, CSWD_SP_ROM, 4'hf, 1'b0, 1'b1);
    chk(tok, 1'b0);
    acc(32'h0010_0000, CSWD_SP_NONE, 4'hf, 1'b1, 1'b0);
    acc(32'h0020_0000, CSWD_SP_CS0, 4'b1110, 1'b0, 1'b0);
    acc(32'h0040_0000, CSWD_SP_CS1, 4'b1101, 1'b0, 1'b0);
    acc(32'h00bf_ffff, CSWD_SP_CS2, 4'b1011, 1'b0, 1'b0);
    acc(32'h00c0_0000, CSWD_SP_CS3, 4'b0111, 1'b0, 1'b0);
    acc(32'h01ff_ffff, CSWD_SP_DRAM, 4'hf, 1'b0, 1'b0);
    acc(32'h0200_0000, CSWD_SP_NONE, 4'hf, 1'b1, 1'b0);
    acc(32'hffff_f000, CSWD_SP_RAM, 4'hf, 1'b0, 1'b0);
    // Timer gate may change later; the low nine bits stay as set up
    wr(ADDR_BUS_CTRL, 16'h2024);
    acc(32'hffff_8000, CSWD_SP_PERI, 4'hf, 1'b0, 1'b1);
    chk(tok, 1'b1);
    // Two reserved hits so far, the last one just past the DRAM end
    rd(ADDR_DECODE_STAT, 16'h0257);
    rd(ADDR_ACCESS_LO, 16'h0000);
    rd(ADDR_ACCESS_HI, 16'h0200);
    // Second power-on: every space longword, fourth one multiplexed
    por(1'b1, 1'b1, 1'b0);
    rd(ADDR_BUS_CTRL, 16'h200f);
    wr(ADDR_BUS_CTRL, 16'h21ff);
    rd(ADDR_BUS_CTRL, 16'h21ff);
    acc(32'h00c0_4000, CSWD_SP_CS3, 4'b0111, 1'b0, 1'b0);
    chk(aw, CSWD_W16);
    wid(CSWD_W32, CSWD_W32, CSWD_W32, CSWD_W16);
    chk(mux, 1'b1);
    acc(32'h00c0_0000, CSWD_SP_CS3, 4'b0111, 1'b0, 1'b0);
    chk(aw, CSWD_W8);
    por(1'b1, 1'b1, 1'b0);
    wr(ADDR_BUS_CTRL, 16'h0088);
    acc(32'h00c0_4000, CSWD_SP_CS3, 4'b0111, 1'b0, 1'b0);
    chk(aw, CSWD_W32);
    wid(CSWD_W8, CSWD_W8, CSWD_W8, CSWD_W32);
    wr(4'hf, 16'h0000);
    rd(4'hf, 16'h0000);
    rd(ADDR_BUS_CTRL, 16'h0088);
    // ROM off, large package: first space usable before setup
    por(1'b0, 1'b1, 1'b0);
    acc(32'h0000_0000, CSWD_SP_CS0, 4'b1110, 1'b0, 1'b0);
    acc(32'h0030_0000, CSWD_SP_CS0, 4'b1110, 1'b0, 1'b0);
    chk(w0, CSWD_W32);
    // Small package: pin sets first space to sixteen bits, setup write sets the rest to eight
    por(1'b0, 1'b0, 1'b0);
    wr(ADDR_BUS_CTRL, 16'h2000);
    wid(CSWD_W16, CSWD_W8, CSWD_W8, CSWD_W8);
    por(1'b1, 1'b1, 1'b1);
    acc(32'h0040_0000, CSWD_SP_NONE, 4'hf, 1'b1, 1'b0);
    acc(32'hffff_f000, CSWD_SP_RAM, 4'hf, 1'b0, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
